// ---- src/meb_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef MEB_REGS_SVH
`define MEB_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define MEB_BUS_CONFIG_REGS_OFS 8'h00
`define MEB_STATUS_OFS 8'h04

// ----------------------------------------------------------------
// bus_config_regs fields
// ----------------------------------------------------------------
`define MEB_CFG_LATCH_EXT_BIT 0
`define MEB_CFG_CYC_TIME_LSB 4
`define MEB_CFG_CYC_TIME_MSB 7
`define MEB_CFG_TRI_WAIT_BIT 8
`define MEB_CFG_STROBE_DLY_BIT 9

// reset: no latch extension, no cycle waits, no tristate wait, strobe delay on
`define MEB_CFG_LATCH_EXT_RST 1'b0
`define MEB_CFG_CYC_TIME_RST 4'hf
`define MEB_CFG_TRI_WAIT_RST 1'b1
`define MEB_CFG_STROBE_DLY_RST 1'b1

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define MEB_STS_BUSY_BIT 0
`define MEB_STS_CLK_BIT 1
`define MEB_STS_COUNT_LSB 16
`define MEB_STS_COUNT_MSB 31

// ----------------------------------------------------------------
// timing, in half_clock_period units (one CLK cycle each)
// ----------------------------------------------------------------
`define MEB_CLK_PERIOD_NS 10
`define MEB_HALF_CLOCK_PERIOD_NS 10
`define MEB_HALF_CLOCK_CYC (`MEB_HALF_CLOCK_PERIOD_NS / `MEB_CLK_PERIOD_NS)
`define MEB_LATCH_BASE 6'h01
`define MEB_HOLD_BASE 6'h01
`define MEB_STROBE_BASE 6'h02
`define MEB_RECOVER_BASE 6'h02
`define MEB_CYC_TIME_MAX 5'h0f

`endif

// ---- src/meb_pkg.sv ----
// types shared by the multiplexed external bus sequencer
package meb_pkg;
  typedef enum logic [2:0] {
    MEB_IDLE,
    MEB_LATCH,
    MEB_HOLD,
    MEB_STROBE,
    MEB_RECOVER
  } meb_state_e;
endpackage

// ---- src/meb_bus_clock.sv ----
// free-running bus clock output, period two half clock periods
module meb_bus_clock (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus clock level
  output logic level
);
  logic next_level;

  // ----------------------------------------------------------------
  // toggle every half clock period
  // ----------------------------------------------------------------
  always_comb begin
    next_level = ~level;
  end

  // register only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
    end else begin
      level <= next_level;
    end
  end
endmodule

// ---- src/meb_seq.sv ----
// multiplexed external bus cycle sequencer with register port
//
// Design decisions made here: strobed register access and the address map.
`include "meb_regs.svh"

// Overview of operation
// - latch phase grows by extension; tristate delay
// - add two half-clocks per missing cycle-time step
// - cycle: six half-clocks plus programmed extras
// - latch falls after bus clock rise
// - strobe low three or two half-clocks plus waits
// - strobe delay moves the strobe leading edge
// - one multiplex waitstate after every cycle
// - tristate wait makes gap two bus clocks
module meb_seq
  import meb_pkg::*;
#(
  parameter int AD_W = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // cycle request
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [AD_W-1:0] REQ_ADDR,
  input wire logic [AD_W-1:0] REQ_WDATA,
  output logic REQ_READY,
  // cycle answer
  output logic RSP_DONE,
  output logic [AD_W-1:0] RSP_RDATA,
  // multiplexed bus pins
  input wire logic [AD_W-1:0] AD_IN,
  output logic [AD_W-1:0] AD_OUT,
  output logic AD_OE,
  output logic LATCH,
  output logic RD_N,
  output logic WR_N,
  output logic BUS_CLK
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (AD_W < 8 || AD_W > 32) begin : g_bad_width
    $error("meb_seq: AD_W must lie between 8 and 32");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  meb_state_e state, next_state;
  logic [5:0] cnt, next_cnt;
  logic [AD_W-1:0] addr, next_addr;
  logic [AD_W-1:0] wdata, next_wdata;
  logic is_write, next_is_write;
  logic cur_ext, next_cur_ext;
  logic [3:0] cur_cyc, next_cur_cyc;
  logic cur_tri, next_cur_tri;
  logic cur_dly, next_cur_dly;
  logic cfg_ext, next_cfg_ext;
  logic [3:0] cfg_cyc, next_cfg_cyc;
  logic cfg_tri, next_cfg_tri;
  logic cfg_dly, next_cfg_dly;
  logic [15:0] cyc_count, next_cyc_count;
  logic [31:0] next_reg_rdata;
  logic [AD_W-1:0] next_rsp_rdata;
  logic next_rsp_done;
  logic [AD_W-1:0] next_ad_out;
  logic next_ad_oe, next_latch, next_rd_n, next_wr_n;
  logic clk_level;
  logic start;
  logic [5:0] latch_len, strobe_len, recover_len;
  logic [31:0] cfg_word, sts_word;

  // ----------------------------------------------------------------
  // bus clock output
  // ----------------------------------------------------------------
  meb_bus_clock u_bus_clock (
    .clk(CLK),
    .rst(RST),
    .level(clk_level)
  );
  assign BUS_CLK = clk_level;

  // ----------------------------------------------------------------
  // phase lengths from the snapshot taken at cycle start
  // ----------------------------------------------------------------
  always_comb begin
    latch_len = `MEB_LATCH_BASE + {5'h00, cur_ext};
    strobe_len = `MEB_STROBE_BASE + {(`MEB_CYC_TIME_MAX - {1'b0, cur_cyc}), 1'b0};
    recover_len = `MEB_RECOVER_BASE + {4'h0, ~cur_tri, 1'b0};
  end

  // a cycle may only open while the bus clock is about to fall,
  // so the latch falls after the next bus clock rise; the last
  // recovery cycle accepts too, so back-to-back cycles keep no gap
  // next cycle follows at once
  assign REQ_READY = ((state == MEB_IDLE) || (state == MEB_RECOVER && cnt == 6'h00)) &&
                     clk_level;
  assign start = REQ_VALID && REQ_READY;

  // ----------------------------------------------------------------
  // cycle sequencer, next values
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_addr = addr;
    next_wdata = wdata;
    next_is_write = is_write;
    next_cur_ext = cur_ext;
    next_cur_cyc = cur_cyc;
    next_cur_tri = cur_tri;
    next_cur_dly = cur_dly;
    next_cyc_count = cyc_count;
    next_rsp_rdata = RSP_RDATA;
    next_rsp_done = 1'b0;
    unique case (state)
      MEB_IDLE: begin
        // nothing to do until a request is taken below
        next_cnt = cnt;
      end
      MEB_LATCH: begin
        if (cnt == 6'h00) begin
          next_state = MEB_HOLD;
          next_cnt = latch_len - `MEB_HOLD_BASE + `MEB_HOLD_BASE - 6'h01;
        end else begin
          next_cnt = cnt - 6'h01;
        end
      end
      MEB_HOLD: begin
        if (cnt == 6'h00) begin
          next_state = MEB_STROBE;
          next_cnt = strobe_len - 6'h01;
        end else begin
          next_cnt = cnt - 6'h01;
        end
      end
      MEB_STROBE: begin
        if (cnt == 6'h00) begin
          next_state = MEB_RECOVER;
          next_cnt = recover_len - 6'h01;
          // sample read data as the strobe rises
          if (!is_write) begin
            next_rsp_rdata = AD_IN;
          end
        end else begin
          next_cnt = cnt - 6'h01;
        end
      end
      MEB_RECOVER: begin
        if (cnt == 6'h00) begin
          next_state = MEB_IDLE;
          next_rsp_done = 1'b1;
          next_cyc_count = cyc_count + 16'h0001;
        end else begin
          next_cnt = cnt - 6'h01;
        end
      end
    endcase
    // a taken request opens a cycle from idle or from the last recovery
    // cycle; config sampled once so a mid-cycle write cannot bend timing
    if (start) begin
      next_state = MEB_LATCH;
      next_cnt = `MEB_LATCH_BASE - 6'h01 + {5'h00, cfg_ext};
      next_addr = REQ_ADDR;
      next_wdata = REQ_WDATA;
      next_is_write = REQ_WRITE;
      next_cur_ext = cfg_ext;
      next_cur_cyc = cfg_cyc;
      next_cur_tri = cfg_tri;
      next_cur_dly = cfg_dly;
    end
  end

  // ----------------------------------------------------------------
  // bus pins, computed from the next state so they leave flip-flops
  // ----------------------------------------------------------------
  always_comb begin
    next_latch = (next_state == MEB_LATCH);
    next_rd_n = 1'b1;
    next_wr_n = 1'b1;
    next_ad_out = '0;
    next_ad_oe = 1'b0;
    if ((next_state == MEB_STROBE) ||
        (next_state == MEB_HOLD && next_cnt == 6'h00 && !next_cur_dly)) begin
      next_rd_n = next_is_write;
      next_wr_n = ~next_is_write;
    end
    unique case (next_state)
      MEB_LATCH, MEB_HOLD: begin
        // address stays valid past the latch fall for its capture
        next_ad_out = next_addr;
        next_ad_oe = 1'b1;
      end
      MEB_STROBE, MEB_RECOVER: begin
        // reads float the lines; writes hold data through recovery
        next_ad_out = next_is_write ? next_wdata : '0;
        next_ad_oe = next_is_write;
      end
      MEB_IDLE: begin
        next_ad_out = '0;
        next_ad_oe = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register file, next values
  // ----------------------------------------------------------------
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[`MEB_CFG_LATCH_EXT_BIT] = cfg_ext;
    cfg_word[`MEB_CFG_CYC_TIME_MSB:`MEB_CFG_CYC_TIME_LSB] = cfg_cyc;
    cfg_word[`MEB_CFG_TRI_WAIT_BIT] = cfg_tri;
    cfg_word[`MEB_CFG_STROBE_DLY_BIT] = cfg_dly;
    sts_word = 32'h0000_0000;
    sts_word[`MEB_STS_BUSY_BIT] = (state != MEB_IDLE);
    sts_word[`MEB_STS_CLK_BIT] = clk_level;
    sts_word[`MEB_STS_COUNT_MSB:`MEB_STS_COUNT_LSB] = cyc_count;
    next_cfg_ext = cfg_ext;
    next_cfg_cyc = cfg_cyc;
    next_cfg_tri = cfg_tri;
    next_cfg_dly = cfg_dly;
    if (REG_WR && REG_ADDR == `MEB_BUS_CONFIG_REGS_OFS) begin
      next_cfg_ext = REG_WDATA[`MEB_CFG_LATCH_EXT_BIT];
      next_cfg_cyc = REG_WDATA[`MEB_CFG_CYC_TIME_MSB:`MEB_CFG_CYC_TIME_LSB];
      next_cfg_tri = REG_WDATA[`MEB_CFG_TRI_WAIT_BIT];
      next_cfg_dly = REG_WDATA[`MEB_CFG_STROBE_DLY_BIT];
    end
    // read data stands one cycle only; unmapped reads give zero
    next_reg_rdata = 32'h0000_0000;
    if (REG_RD) begin
      if (REG_ADDR == `MEB_BUS_CONFIG_REGS_OFS) begin
        next_reg_rdata = cfg_word;
      end else if (REG_ADDR == `MEB_STATUS_OFS) begin
        next_reg_rdata = sts_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= MEB_IDLE;
      cnt <= 6'h00;
      addr <= '0;
      wdata <= '0;
      is_write <= 1'b0;
      cur_ext <= `MEB_CFG_LATCH_EXT_RST;
      cur_cyc <= `MEB_CFG_CYC_TIME_RST;
      cur_tri <= `MEB_CFG_TRI_WAIT_RST;
      cur_dly <= `MEB_CFG_STROBE_DLY_RST;
      cyc_count <= 16'h0000;
      RSP_RDATA <= '0;
      RSP_DONE <= 1'b0;
      AD_OUT <= '0;
      AD_OE <= 1'b0;
      LATCH <= 1'b0;
      RD_N <= 1'b1;
      WR_N <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      addr <= next_addr;
      wdata <= next_wdata;
      is_write <= next_is_write;
      cur_ext <= next_cur_ext;
      cur_cyc <= next_cur_cyc;
      cur_tri <= next_cur_tri;
      cur_dly <= next_cur_dly;
      cyc_count <= next_cyc_count;
      RSP_RDATA <= next_rsp_rdata;
      RSP_DONE <= next_rsp_done;
      AD_OUT <= next_ad_out;
      AD_OE <= next_ad_oe;
      LATCH <= next_latch;
      RD_N <= next_rd_n;
      WR_N <= next_wr_n;
    end
  end

  // configuration and read data registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg_ext <= `MEB_CFG_LATCH_EXT_RST;
      cfg_cyc <= `MEB_CFG_CYC_TIME_RST;
      cfg_tri <= `MEB_CFG_TRI_WAIT_RST;
      cfg_dly <= `MEB_CFG_STROBE_DLY_RST;
      REG_RDATA <= 32'h0000_0000;
    end else begin
      cfg_ext <= next_cfg_ext;
      cfg_cyc <= next_cfg_cyc;
      cfg_tri <= next_cfg_tri;
      cfg_dly <= next_cfg_dly;
      REG_RDATA <= next_reg_rdata;
    end
  end
endmodule

// ---- test/meb_seq_assertions.sv ----
// assertion checker for the multiplexed external bus sequencer
module meb_seq_checker (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register writes
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  // request handshake
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic RSP_DONE,
  // bus pins
  input wire logic LATCH,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic BUS_CLK
);
  logic [9:0] cfg;
  logic [6:0] low_cnt;
  logic [6:0] run_cnt;
  logic [6:0] gap_cnt;
  logic lat_q;
  logic strb;
  int exp_low;
  int exp_t;

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  // high while neither command strobe is low
  assign strb = RD_N & WR_N;
  assign exp_low = (cfg[9] ? 2 : 3) + 2 * (15 - cfg[7:4]);
  assign exp_t = 6 + 2 * cfg[0] + 2 * (15 - cfg[7:4]) + 2 * (1 - cfg[8]);

  // config shadow; the bench only rewrites it while idle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg <= 10'h3f0;
      low_cnt <= 7'h00;
      run_cnt <= 7'h00;
      gap_cnt <= 7'h00;
      lat_q <= 1'b0;
    end else begin
      if (REG_WR && REG_ADDR == 8'h00) begin
        cfg <= REG_WDATA[9:0] & 10'h3f1;
      end
      low_cnt <= strb ? 7'h00 : low_cnt + 7'h01;
      run_cnt <= (REQ_VALID && REQ_READY) ? 7'h00 : run_cnt + 7'h01;
      // cycles since the latch strobe last rose
      lat_q <= LATCH;
      gap_cnt <= (LATCH && !lat_q) ? 7'h01 : gap_cnt + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_clk_period: assert property (BUS_CLK |=> !BUS_CLK ##1 BUS_CLK)
    else $error("bus clock period is not two cycles");
  a_latch_at_clk: assert property ($fell(LATCH) |-> BUS_CLK == !cfg[0])
    else $error("latch fall not aligned to bus clock");
  a_latch_plain: assert property ($rose(LATCH) && !cfg[0] |=> !LATCH)
    else $error("latch high time wrong without extension");
  a_latch_ext: assert property ($rose(LATCH) && cfg[0] |=> LATCH ##1 !LATCH)
    else $error("latch high time wrong with extension");
  a_strobe_low: assert property ($rose(strb) |-> low_cnt == exp_low)
    else $error("strobe low time wrong");
  a_strobe_lead: assert property ($fell(LATCH) |-> strb == (cfg[9] | cfg[0]))
    else $error("strobe leading edge wrong");
  a_mux_wait: assert property ($rose(strb) |-> !LATCH[*2])
    else $error("multiplex waitstate missing");
  a_tri_wait: assert property ($rose(strb) && !cfg[8] |-> !LATCH[*4])
    else $error("tristate gap shorter than two bus clocks");
  a_cycle_len: assert property (RSP_DONE |-> $past(run_cnt) == exp_t - 1)
    else $error("external cycle length wrong");
  a_latch_period: assert property ($rose(LATCH) && RSP_DONE |-> gap_cnt == exp_t)
    else $error("back-to-back latch period wrong");
endmodule

bind meb_seq meb_seq_checker chk (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
  .RSP_DONE(RSP_DONE), .LATCH(LATCH), .RD_N(RD_N), .WR_N(WR_N), .BUS_CLK(BUS_CLK));

// ---- test/meb_mem_model.sv ----
// behavioural memory behind the external address latch
module meb_mem_model (
  // clock
  input wire logic clk,
  // strobes
  input wire logic latch,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ad_oe,
  // multiplexed lines
  input wire logic [15:0] ad_out,
  output logic [15:0] ad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  logic [3:0] lat = 4'h0;

  initial for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  // address latch capture
  // an address not driven by the sequencer lands on word zero
  always @(negedge latch) lat = ad_oe ? ad_out[3:0] : 4'h0;
  // store only driven data, remember the last value read
  always @(posedge clk) begin
    if (!wr_n && ad_oe) mem[lat] <= ad_out;
    if (!rd_n) last <= mem[lat];
  end
  // released or contended lines show the inverse of the last value
  assign ad_in = (rd_n || ad_oe) ? ~last : mem[lat];
endmodule

// ---- test/mux_external_bus_cycle_test.sv ----
// self-checking bench for the multiplexed external bus sequencer
module mux_external_bus_cycle_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, r, seed = 32'h63db;
  logic reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [15:0] req_addr = 16'h0, req_wdata = 16'h0, rsp_rdata, ad_in, ad_out, a, d, q;
  logic req_ready, rsp_done, ad_oe, latch, rd_n, wr_n, bus_clk;
  logic [15:0] exp_mem [16];
  logic [9:0] cfg;
  int n_fail = 0, samples_checked = 0;

  always #5 clk = ~clk;

  meb_seq dut (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REQ_VALID(req_valid),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .REQ_READY(req_ready), .RSP_DONE(rsp_done), .RSP_RDATA(rsp_rdata), .AD_IN(ad_in),
    .AD_OUT(ad_out), .AD_OE(ad_oe), .LATCH(latch), .RD_N(rd_n), .WR_N(wr_n),
    .BUS_CLK(bus_clk));
  meb_mem_model mem (.clk(clk), .latch(latch), .rd_n(rd_n), .wr_n(wr_n), .ad_oe(ad_oe),
    .ad_out(ad_out), .ad_in(ad_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // edges from take to done for a given config
  function automatic int exp_len(logic [9:0] c);
    return 6 + 2 * c[0] + 2 * (15 - c[7:4]) + 2 * (1 - c[8]);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] ad, output logic [31:0] dt);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    dt = reg_rdata;
  endtask

  // ready is combinational, so it is only looked at on falling edges
  task automatic wait_ready(output int t);
    for (t = 0; t < 60; t++) begin
      @(negedge clk);
      if (req_ready === 1'b1) break;
    end
    if (t == 60) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  // counts falling edges to the done pulse; skip ignores one already standing
  task automatic wait_done(input logic skip, output int t);
    for (t = 0; t < 60; t++) begin
      @(negedge clk);
      if (rsp_done === 1'b1 && !(skip && t == 0)) break;
    end
    if (t == 60) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  // one external cycle; sampling on the falling edge keeps clear of update races
  task automatic xfer(input logic w, input logic [15:0] ad, input logic [15:0] dt,
                      output logic [15:0] rd);
    int t;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= ad;
    req_wdata <= dt;
    wait_ready(t);
    @(posedge clk);
    req_valid <= 1'b0;
    wait_done(1'b0, t);
    chk(t, exp_len(cfg));
    rd = rsp_rdata;
  endtask

  // two writes back to back: the second is taken as the first ends
  task automatic burst(input logic [15:0] a1, d1, a2, d2);
    int t;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= 1'b1;
    req_addr <= a1;
    req_wdata <= d1;
    wait_ready(t);
    @(posedge clk);
    req_addr <= a2;
    req_wdata <= d2;
    wait_ready(t);
    chk(t, exp_len(cfg) - 1);
    @(posedge clk);
    req_valid <= 1'b0;
    wait_done(1'b1, t);
    chk(t, exp_len(cfg));
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset config, unmapped place ignored
    reg_read(8'h00, r);
    chk(r, 32'h3f0);
    reg_write(8'h08, 32'hffffffff);
    reg_read(8'h08, r);
    chk(r, 32'h0);
    // reset config, then all-extras corner, then random configs
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      cfg = (i == 0) ? 10'h3f0 : (i == 1) ? 10'h001 : r[9:0] & 10'h3f1;
      reg_write(8'h00, {22'h0, cfg});
      reg_read(8'h00, r);
      chk(r, {22'h0, cfg});
      r = rnd();
      a = r[15:0];
      d = r[31:16];
      xfer(1'b1, a, d, q);
      exp_mem[a[3:0]] = d;
      xfer(1'b0, a, 16'h0000, q);
      chk({16'h0, q}, {16'h0, exp_mem[a[3:0]]});
    end
    // back-to-back writes at the shortest and the longest cycle
    for (int j = 0; j < 2; j++) begin
      cfg = (j == 0) ? 10'h3f0 : 10'h001;
      reg_write(8'h00, {22'h0, cfg});
      r = rnd();
      a = r[15:0];
      d = r[31:16];
      r = rnd();
      burst(a, d, {a[15:4], ~a[3:0]}, r[15:0]);
      xfer(1'b0, a, 16'h0000, q);
      chk({16'h0, q}, {16'h0, d});
      xfer(1'b0, {a[15:4], ~a[3:0]}, 16'h0000, q);
      chk({16'h0, q}, {16'h0, r[15:0]});
    end
    // status is read-only and counts completed cycles
    reg_write(8'h04, 32'hffffffff);
    reg_read(8'h04, r);
    chk({r[31:16], 15'h0, r[0]}, {16'h0038, 16'h0000});
    report_and_stop();
  end
endmodule
